// ---- efc_pkg.sv ----
// package: constants and types for the error converter front end control
`default_nettype none
package efc_pkg;
	localparam int EFC_CODE_W = 9;
	localparam int EFC_RES_W = 9;
	localparam int EFC_SP_MAIN_W = 10;
	localparam int EFC_SP_FRAC_W = 4;
	localparam int EFC_CNT_W = 14;
	localparam int EFC_RAMP_W = 8;
	localparam logic [1:0] EFC_GAIN_1 = 2'h0;
	localparam logic [1:0] EFC_GAIN_8 = 2'h3;
	localparam logic [1:0] EFC_OVS_1X = 2'h0;
	localparam logic [1:0] EFC_SP_FIXED = 2'h0;
	localparam logic [1:0] EFC_SP_SOFT = 2'h1;
	localparam logic [1:0] EFC_SP_OUTER = 2'h2;
	localparam logic [1:0] EFC_SP_SLOPE = 2'h3;
	localparam logic [EFC_RES_W-1:0] EFC_RES_MAX = 9'h0ff;
	localparam logic [EFC_RES_W-1:0] EFC_RES_MIN = 9'h100;
	localparam logic [EFC_SP_MAIN_W+EFC_SP_FRAC_W-1:0] EFC_SP_RST = 14'h0000;
	typedef enum logic [1:0] {
		EFC_IDLE = 2'b00,
		EFC_CONV = 2'b01,
		EFC_SCALE = 2'b10
	} efc_state_t;
endpackage : efc_pkg
`default_nettype wire

// ---- efc_buf2.sv ----
// two-entry valid/ready buffer for the result stream
`default_nettype none
module efc_buf2
	import efc_pkg::*;
#(
	parameter int W = 9
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	initial begin
		if (W < 1) $error("efc_buf2: width must be positive");
	end
	logic [W-1:0] mem_q [2];
	logic [W-1:0] mem_d [2];
	logic wp_q, wp_d, rp_q, rp_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop;
	always_comb begin
		push = in_valid && (cnt_q != 2'h2);
		pop = out_ready && (cnt_q != 2'h0);
		mem_d = mem_q;
		wp_d = wp_q;
		rp_d = rp_q;
		if (push) begin
			mem_d[wp_q] = in_data;
			wp_d = ~wp_q;
		end
		if (pop) begin
			rp_d = ~rp_q;
		end
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if (ce) begin
			mem_q <= mem_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end
	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rp_q];
endmodule : efc_buf2
`default_nettype wire

// ---- efc_front_end.sv ----
// error converter front end control: trigger, capture, scale, strobe, set-point
// Function
// - result is 9-bit sign-extended two's complement, one lsb per millivolt
// - analog gain, converter and digital gain give 9-bit range, 6-bit resolution
// - one converter step equals 1, 2, 4 or 8 result lsbs by gain range
// - auto range picks finest gain range whose result still fits the range
// - conversions start only on a sample request from the pulse width generator
// - on conversion done, latch 9-bit code and strobe the compensator
// - set-point has 10-bit main plus 4-bit fraction dithered across samples
// - set-point source selectable: fixed, soft-start ramp, outer loop, slope ramp
// - option inverts the sign of the error before the compensator
// - absolute mode adds the current set-point to the measured error
// - slope ramp steps set-point down by programmable step on each conversion start while above the step, reloading each switching cycle
// - sample request when trigger count equals running generator counter
// - oversampling codes 00..11 give 1, 2, 4, 8 evenly spaced samples per period
`default_nettype none
module efc_front_end
	import efc_pkg::*;
#(
	parameter int CNT_W = EFC_CNT_W
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [CNT_W-1:0] pulse_width_generator_cnt,
	input wire logic [CNT_W-1:0] pulse_width_generator_period,
	input wire logic [CNT_W-1:0] sample_trigger_cnt,
	input wire logic [1:0] oversample_sel,
	input wire logic error_converter_done,
	input wire logic [EFC_CODE_W-1:0] error_converter_code,
	input wire logic [1:0] gain_range_select,
	input wire logic auto_range_en,
	input wire logic invert_en,
	input wire logic absolute_en,
	input wire logic [1:0] sp_source_sel,
	input wire logic [EFC_SP_MAIN_W-1:0] sp_main,
	input wire logic [EFC_SP_FRAC_W-1:0] sp_frac,
	input wire logic [EFC_SP_MAIN_W+EFC_SP_FRAC_W-1:0] sp_outer,
	input wire logic [EFC_RAMP_W-1:0] sp_ramp_step,
	input wire logic sp_ramp_restart,
	output logic error_converter_start,
	output logic [1:0] gain_range_used,
	output logic [EFC_SP_MAIN_W-1:0] sp_dac,
	output logic result_valid,
	input wire logic result_ready,
	output logic [EFC_RES_W-1:0] result_data,
	output logic result_strobe,
	output logic busy
);
	localparam int SPW = EFC_SP_MAIN_W + EFC_SP_FRAC_W;
	initial begin
		if (CNT_W < 4 || CNT_W > 16) $error("efc_front_end: counter width out of range");
	end

	efc_state_t st_q, st_d;
	logic start_q, start_d;
	logic [EFC_CODE_W-1:0] code_q, code_d;
	logic [1:0] gain_q, gain_d;
	logic [EFC_RES_W-1:0] res_q, res_d;
	logic rv_q, rv_d;
	logic strobe_q, strobe_d;
	logic [SPW-1:0] sp_q, sp_d;
	logic [EFC_SP_FRAC_W-1:0] dith_q, dith_d;
	logic [EFC_SP_MAIN_W-1:0] dac_q, dac_d;
	logic [CNT_W-1:0] spacing;
	logic sample_req;
	logic period_end;
	logic in_ready;
	logic bv, bo_valid;
	logic [EFC_RES_W-1:0] bo_data;
	logic bpop;
	logic busy_q, busy_d;
	logic signed [EFC_RES_W+SPW:0] wide;
	logic signed [EFC_RES_W+SPW:0] sum;

	// sample request, evenly spaced oversampling
	always_comb begin
		spacing = pulse_width_generator_period >> oversample_sel;
		sample_req = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if (k < (1 << oversample_sel)) begin
				if (pulse_width_generator_cnt == CNT_W'(sample_trigger_cnt + CNT_W'(k) * spacing)) begin
					sample_req = 1'b1;
				end
			end
		end
		period_end = (pulse_width_generator_cnt == pulse_width_generator_period);
	end

	// scaling of one converter code into a result
	function automatic logic signed [EFC_RES_W+SPW:0] scale(input logic [EFC_CODE_W-1:0] c,
			input logic [1:0] g);
		logic signed [EFC_RES_W+SPW:0] v;
		v = (EFC_RES_W + SPW + 1)'(signed'(c));
		scale = v <<< g;
	endfunction : scale

	function automatic logic fits(input logic signed [EFC_RES_W+SPW:0] v);
		fits = (v <= (EFC_RES_W + SPW + 1)'(signed'(EFC_RES_MAX))) &&
			(v >= (EFC_RES_W + SPW + 1)'(signed'(EFC_RES_MIN)));
	endfunction : fits

	always_comb begin
		st_d = st_q;
		start_d = 1'b0;
		code_d = code_q;
		gain_d = gain_q;
		res_d = res_q;
		rv_d = 1'b0;
		strobe_d = 1'b0;
		wide = '0;
		sum = '0;
		unique case (st_q)
			EFC_IDLE: begin
				if (sample_req && in_ready) begin
					start_d = 1'b1;
					st_d = EFC_CONV;
				end
			end
			EFC_CONV: begin
				if (error_converter_done) begin
					code_d = error_converter_code;
					st_d = EFC_SCALE;
				end
			end
			EFC_SCALE: begin
				wide = scale(code_q, gain_range_select);
				gain_d = gain_range_select;
				if (auto_range_en) begin
					// finest gain whose scaled value fits, else coarsest
					gain_d = EFC_GAIN_8;
					for (int g = 3; g >= 0; g--) begin
						if (fits(scale(code_q, 2'(g)))) begin
							gain_d = 2'(g);
						end
					end
					wide = scale(code_q, gain_d);
				end
				if (invert_en) begin
					wide = -wide;
				end
				sum = wide;
				if (absolute_en) begin
					sum = wide + (EFC_RES_W + SPW + 1)'(sp_q >> EFC_SP_FRAC_W);
				end
				if (sum > (EFC_RES_W + SPW + 1)'(signed'(EFC_RES_MAX))) begin
					res_d = EFC_RES_MAX;
				end else if (sum < (EFC_RES_W + SPW + 1)'(signed'(EFC_RES_MIN))) begin
					res_d = EFC_RES_MIN;
				end else begin
					res_d = sum[EFC_RES_W-1:0];
				end
				rv_d = 1'b1;
				strobe_d = 1'b1;
				st_d = EFC_IDLE;
			end
			default: st_d = EFC_IDLE;
		endcase
		busy_d = (st_d != EFC_IDLE);
	end

	// set-point source and dither
	always_comb begin
		sp_d = sp_q;
		dith_d = dith_q;
		dac_d = dac_q;
		unique case (sp_source_sel)
			EFC_SP_FIXED: sp_d = {sp_main, sp_frac};
			EFC_SP_OUTER: sp_d = sp_outer;
			EFC_SP_SOFT: begin
				if (sp_ramp_restart) begin
					sp_d = EFC_SP_RST;
				end else if (period_end && sp_q < {sp_main, sp_frac}) begin
					sp_d = ({sp_main, sp_frac} - sp_q > SPW'(sp_ramp_step)) ?
						SPW'(sp_q + SPW'(sp_ramp_step)) : {sp_main, sp_frac};
				end
			end
			EFC_SP_SLOPE: begin
				if (sp_ramp_restart || period_end) begin
					sp_d = {sp_main, sp_frac};
				end else if (start_q && sp_q > SPW'(sp_ramp_step)) begin
					sp_d = SPW'(sp_q - SPW'(sp_ramp_step));
				end
			end
		endcase
		if (start_q) begin
			dith_d = EFC_SP_FRAC_W'(dith_q + 1'b1);
			dac_d = sp_q[SPW-1:EFC_SP_FRAC_W] +
				EFC_SP_MAIN_W'(dith_q < sp_q[EFC_SP_FRAC_W-1:0]);
			if (sp_q[SPW-1:EFC_SP_FRAC_W] == {EFC_SP_MAIN_W{1'b1}}) begin
				dac_d = sp_q[SPW-1:EFC_SP_FRAC_W];
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= EFC_IDLE;
			start_q <= 1'b0;
			code_q <= '0;
			gain_q <= EFC_GAIN_1;
			res_q <= '0;
			rv_q <= 1'b0;
			strobe_q <= 1'b0;
			sp_q <= EFC_SP_RST;
			dith_q <= '0;
			dac_q <= '0;
			busy_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			start_q <= start_d;
			code_q <= code_d;
			gain_q <= gain_d;
			res_q <= res_d;
			rv_q <= rv_d;
			strobe_q <= strobe_d;
			sp_q <= sp_d;
			dith_q <= dith_d;
			dac_q <= dac_d;
			busy_q <= busy_d;
		end
	end

	efc_buf2 #(
		.W(EFC_RES_W)
	) u_buf (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.in_valid(rv_q),
		.in_ready(in_ready),
		.in_data(res_q),
		.out_valid(bo_valid),
		.out_ready(bpop),
		.out_data(bo_data)
	);

	// registered stream outputs; data holds until the next word is taken
	logic ov_q, ov_d;
	logic [EFC_RES_W-1:0] od_q, od_d;
	logic ostb_q, ostb_d;
	always_comb begin
		bv = bo_valid;
		bpop = bv && (!ov_q || result_ready);
		ov_d = ov_q;
		od_d = od_q;
		ostb_d = 1'b0;
		if (ov_q && result_ready) begin
			ov_d = 1'b0;
		end
		if (bpop) begin
			ov_d = 1'b1;
			od_d = bo_data;
			ostb_d = 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ov_q <= 1'b0;
			od_q <= '0;
			ostb_q <= 1'b0;
		end else if (ce) begin
			ov_q <= ov_d;
			od_q <= od_d;
			ostb_q <= ostb_d;
		end
	end

	assign error_converter_start = start_q;
	assign gain_range_used = gain_q;
	assign sp_dac = dac_q;
	assign result_valid = ov_q;
	assign result_data = od_q;
	assign result_strobe = ostb_q;
	assign busy = busy_q;
endmodule : efc_front_end
`default_nettype wire

// ---- efc_far.sv ----
// far side model: generator counter and error converter
`default_nettype none
module efc_far
	import efc_pkg::*;
#(
	parameter int CNT_W = EFC_CNT_W
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [CNT_W-1:0] period,
	input wire logic slow,
	input wire logic start,
	input wire logic [EFC_CODE_W-1:0] code_in,
	output logic [CNT_W-1:0] cnt,
	output logic done,
	output logic [EFC_CODE_W-1:0] code
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wait_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
			wait_q <= '0;
			done <= 1'b0;
			code <= '0;
		end else begin
			cnt <= (cnt >= period) ? '0 : cnt + 1'b1;
			done <= (wait_q == 3'h1);
			code <= (wait_q == 3'h1) ? code_in : ~code;
			if (start) begin
				wait_q <= slow ? 3'h4 : 3'h1;
			end else if (wait_q != 3'h0) begin
				wait_q <= wait_q - 3'h1;
			end
		end
	end
endmodule : efc_far
`default_nettype wire

// ---- efc_chk_checker.sv ----
// assertion checker for the front end control
`default_nettype none
module efc_chk
	import efc_pkg::*;
#(
	parameter int CNT_W = EFC_CNT_W
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [CNT_W-1:0] pulse_width_generator_cnt,
	input wire logic [CNT_W-1:0] sample_trigger_cnt,
	input wire logic [1:0] oversample_sel,
	input wire logic error_converter_done,
	input wire logic error_converter_start,
	input wire logic result_valid,
	input wire logic result_ready,
	input wire logic [EFC_RES_W-1:0] result_data,
	input wire logic result_strobe,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	AST_START_SPACE: assert property (error_converter_start |=> !error_converter_start [*2])
		else $error("start spacing");
	AST_START_IDLE: assert property (error_converter_start |-> !$past(busy) && busy)
		else $error("start while busy");
	AST_START_TRIG: assert property (error_converter_start && $past(oversample_sel) == EFC_OVS_1X
		|-> $past(pulse_width_generator_cnt) == $past(sample_trigger_cnt)) else $error("start off trigger");
	AST_DONE_RESULT: assert property (error_converter_done && busy |-> ##4 result_valid)
		else $error("no result");
	AST_STROBE_VALID: assert property (result_strobe |-> result_valid &&
		(!$past(result_valid) || $past(result_ready))) else $error("strobe shape");
	AST_ROSE_STROBE: assert property ($rose(result_valid) |-> result_strobe)
		else $error("valid without strobe");
	AST_HOLD: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
		else $error("result moved");
	AST_STALL_QUIET: assert property (result_valid && !result_ready |=> !result_strobe)
		else $error("strobe in stall");
endmodule : efc_chk
bind efc_front_end efc_chk #(.CNT_W(CNT_W)) i_chk (.mclk, .rstn, .pulse_width_generator_cnt, .sample_trigger_cnt,
	.oversample_sel, .error_converter_done, .error_converter_start, .result_valid, .result_ready, .result_data,
	.result_strobe, .busy);
`default_nettype wire

// ---- tb.sv ----
// self-checking testbench for the front end control
`default_nettype none
module tb;
	import efc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 64;
	logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, auto_range_en = 1'b0, invert_en = 1'b0, absolute_en = 1'b0;
	logic sp_ramp_restart = 1'b0, result_ready = 1'b1, slow = 1'b0, error_converter_done, error_converter_start;
	logic result_valid, result_strobe, busy, prev;
	logic [1:0] oversample_sel = 2'h0, gain_range_select = 2'h0, sp_source_sel = 2'h0, gain_range_used;
	logic [13:0] pulse_width_generator_cnt, sample_trigger_cnt = 14'h0005, pulse_width_generator_period = 14'h003f;
	logic [13:0] sp_outer = 14'h0000;
	logic [9:0] sp_main = 10'h000, sp_dac;
	logic [3:0] sp_frac = 4'h0;
	logic [7:0] sp_ramp_step = 8'h00;
	logic [8:0] error_converter_code, code_in = 9'h000, result_data;
	int failures = 0, checked = 0, cyc = 0, n, hi;
	efc_front_end i_dut (.mclk, .rstn, .ce, .pulse_width_generator_cnt, .pulse_width_generator_period,
		.sample_trigger_cnt, .oversample_sel, .error_converter_done, .error_converter_code, .gain_range_select,
		.auto_range_en, .invert_en, .absolute_en, .sp_source_sel, .sp_main, .sp_frac, .sp_outer, .sp_ramp_step,
		.sp_ramp_restart, .error_converter_start, .gain_range_used, .sp_dac, .result_valid, .result_ready,
		.result_data, .result_strobe, .busy);
	efc_far i_far (.mclk, .rstn, .period(pulse_width_generator_period), .slow, .start(error_converter_start),
		.code_in, .cnt(pulse_width_generator_cnt), .done(error_converter_done), .code(error_converter_code));
	initial begin
		forever #4 mclk = ~mclk;
	end
	task wrap_up;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 10000) begin
			failures++;
			wrap_up;
		end
	end
	task chk(input logic [13:0] got, input logic [13:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wait_res;
		for (int i = 0; i < 600; i++) begin
			@(negedge mclk);
			if (result_strobe === 1'b1) break;
			if (i == 599) begin
				failures++;
				$display("Error at %0t: no result", $time);
			end
		end
	endtask : wait_res
	task wait_start;
		for (int i = 0; i < 600; i++) begin
			@(negedge mclk);
			if (error_converter_start === 1'b1) break;
		end
		@(negedge mclk);
	endtask : wait_start
	task run(input logic [8:0] c, input logic [8:0] e, input logic [1:0] g);
		@(posedge mclk);
		code_in <= c;
		wait_res;
		wait_res;
		chk(result_data, e);
		chk(gain_range_used, g);
	endtask : run
	task t_gain;
		for (int g = 0; g < 4; g++) begin
			@(posedge mclk);
			gain_range_select <= 2'(g);
			run(9'h005, 9'(5 << g), 2'(g));
		end
		run(9'h040, EFC_RES_MAX, EFC_GAIN_8);
		run(9'h1c0, EFC_RES_MIN, EFC_GAIN_8);
		$display("gain test done");
	endtask : t_gain
	task t_mode;
		@(posedge mclk);
		gain_range_select <= EFC_GAIN_1;
		invert_en <= 1'b1;
		run(9'h007, 9'h1f9, EFC_GAIN_1);
		@(posedge mclk);
		invert_en <= 1'b0;
		gain_range_select <= EFC_GAIN_8;
		auto_range_en <= 1'b1;
		run(9'h028, 9'h028, EFC_GAIN_1);
		@(posedge mclk);
		gain_range_select <= EFC_GAIN_1;
		auto_range_en <= 1'b0;
		absolute_en <= 1'b1;
		slow <= 1'b1;
		sp_main <= 10'h014;
		sp_outer <= 14'h01e0;
		run(9'h003, 9'h017, EFC_GAIN_1);
		@(posedge mclk);
		sp_source_sel <= EFC_SP_OUTER;
		run(9'h003, 9'h021, EFC_GAIN_1);
		@(posedge mclk);
		absolute_en <= 1'b0;
		slow <= 1'b0;
		sp_source_sel <= EFC_SP_FIXED;
		$display("mode test done");
	endtask : t_mode
	task t_stall;
		run(9'h011, 9'h011, EFC_GAIN_1);
		@(posedge mclk);
		result_ready <= 1'b0;
		code_in <= 9'h022;
		repeat (3 * P) @(negedge mclk);
		chk(result_valid, 1'b1);
		chk(result_data, 9'h022);
		@(posedge mclk);
		result_ready <= 1'b1;
		wait_res;
		chk(result_data, 9'h022);
		$display("stall test done");
	endtask : t_stall
	task t_ovs;
		@(posedge mclk);
		sp_main <= 10'h00a;
		sp_frac <= 4'h8;
		for (int s = 0; s < 4; s++) begin
			@(posedge mclk);
			oversample_sel <= 2'(s);
			repeat (2 * P) @(negedge mclk);
			n = 0;
			hi = 0;
			prev = 1'b0;
			repeat (4 * P) begin
				@(negedge mclk);
				if (error_converter_start === 1'b1) n++;
				if (prev === 1'b1 && sp_dac === 10'h00b) hi++;
				prev = error_converter_start;
			end
			@(negedge mclk);
			if (prev === 1'b1 && sp_dac === 10'h00b) hi++;
			chk(n, 4 << s);
		end
		chk(hi, 16);
		$display("oversample test done");
	endtask : t_ovs
	task t_ce;
		wait_res;
		@(posedge mclk);
		ce <= 1'b0;
		n = 0;
		repeat (2 * P) begin
			@(negedge mclk);
			if (error_converter_start === 1'b1 || result_strobe === 1'b1) n++;
		end
		chk(n, 0);
		chk(busy, 1'b0);
		chk(result_valid, 1'b0);
		@(posedge mclk);
		ce <= 1'b1;
		code_in <= 9'h033;
		wait_res;
		wait_res;
		chk(result_data, 9'h033);
		$display("clock enable test done");
	endtask : t_ce
	task t_reset;
		wait_res;
		@(posedge mclk);
		rstn <= 1'b0;
		@(negedge mclk);
		chk({result_valid, result_strobe, error_converter_start, busy}, 4'h0);
		chk(result_data, 9'h000);
		chk(sp_dac, 10'h000);
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		wait_res;
		wait_res;
		chk(result_data, 9'h033);
		$display("reset test done");
	endtask : t_reset
	task t_ramp;
		@(posedge mclk);
		oversample_sel <= EFC_OVS_1X;
		sp_frac <= 4'h0;
		sp_main <= 10'h005;
		sp_ramp_step <= 8'h10;
		sp_source_sel <= EFC_SP_SOFT;
		repeat (2) wait_start;
		@(posedge mclk);
		sp_ramp_restart <= 1'b1;
		@(posedge mclk);
		sp_ramp_restart <= 1'b0;
		for (int k = 1; k < 7; k++) begin
			wait_start;
			chk(sp_dac, 14'((k < 5) ? k : 5));
		end
		@(posedge mclk);
		sp_main <= 10'h020;
		oversample_sel <= 2'h3;
		sp_source_sel <= EFC_SP_SLOPE; // slope compensation for peak current mode
		repeat (9) wait_start;
		n = 0;
		hi = 0;
		repeat (16) begin
			wait_start;
			if (sp_dac === 10'h020) n++;
			if (sp_dac === 10'h019) hi++;
		end
		chk(n, 2);
		chk(hi, 2);
		$display("ramp test done");
	endtask : t_ramp
	initial begin
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		t_gain;
		t_mode;
		t_stall;
		t_ce;
		t_reset;
		t_ovs;
		t_ramp;
		wrap_up;
	end
endmodule : tb
`default_nettype wire
